//--- verilog/iswc_pkg.sv
// iswc_pkg: constants and carrier types for the interrupt and sleep/wake
// control block; assumes a 40 MHz system clock.
package iswc_pkg;
  localparam int          NUM_SRC        = 15;
  localparam int          SRC_W          = 4;
  localparam int          GLOBAL_EN_BIT  = 7;
  localparam int          IDLE_BIT       = 0;
  localparam int          STOP_BIT       = 1;
  localparam int          DROPOUT_SRC    = 13;
  localparam int          DROPOUT_EN_BIT = 6;
  localparam logic [7:0]  ENABLE_RST     = 8'h00;
  localparam logic [7:0]  PRIO_RST       = 8'h00;
  localparam logic [15:0] RESET_VECTOR   = 16'h0000;
  localparam logic [15:0] VECTOR_BASE    = 16'h0003;
  localparam int          VECTOR_STEP    = 8;
  localparam int          DETECT_CYCLES  = 1;
  localparam int          CALL_CYCLES    = 4;
  localparam int          MIN_RESPONSE   = DETECT_CYCLES + CALL_CYCLES;
  localparam int          MAX_RESPONSE   = 18;
  localparam int          SYNC_STAGES    = 2;

  typedef struct packed {
    logic [7:0] irq_enable_reg;
    logic [7:0] ext_irq_enable_reg;
    logic [7:0] irq_priority_reg;
    logic [7:0] ext_irq_priority_reg;
  } iswc_cfg_type;

  typedef struct packed {
    logic        valid;
    logic [3:0]  src;
    logic        high;
    logic [15:0] vector;
  } iswc_call_type;
endpackage : iswc_pkg

//--- verilog/iswc_sync.sv
// iswc_sync: two-flop synchroniser for a bus of pin levels.
// assumes the inputs are asynchronous to i_clk.
`timescale 1ns/1ps
module iswc_sync #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  // levels
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } iswc_sync_state_type;

  iswc_sync_state_type state_ff;
  iswc_sync_state_type nxt_state;

  if (WIDTH < 1) begin : g_bad_width
    $error("iswc_sync: WIDTH must be positive");
  end

  always_comb begin
    nxt_state      = state_ff;
    nxt_state.meta = i_async;
    nxt_state.sync = state_ff.meta;
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_sync = state_ff.sync;
endmodule : iswc_sync

//--- verilog/iswc_top.sv
// iswc_top: interrupt arbitration, vectoring and idle/stop control.
// assumes a core sequencer that flags instruction boundaries and returns,
// and peripherals whose event pulses arrive on the system clock.
`timescale 1ns/1ps
// Function
// [R1] source event sets pending flag regardless enable
// [R2] enabled pending source requests vectored long call
// [R3] global enable gates all; flags stay pending
// [R4] selected flags auto-clear on vectoring
// [R5] still-pending flag after return re-requests
// [R6] software-set flag behaves like hardware event
// [R7] fifteen sources, own vector, enable, priority
// [R8] high preempts low; high never preempted
// [R9] priorities reset low, change by bit
// [R10] higher level first; ties by fixed order
// [R11] sampled every clock; minimum five cycle response
// [R12] one instruction after return before call
// [R13] latency at most eighteen cycles uncontested
// [R14] equal-or-higher active routine blocks new request
// [R15] idle bit halts execution, keeps state
// [R16] enabled interrupt clears idle and resumes
// [R17] reset ending idle restarts at zero
// [R18] watchdog reset ends idle when enabled
// [R19] stop bit halts clock; only reset ends
// [R20] software disables clock detector before long stop
// [R21] dropout requests interrupt without pending flag
// [R22] dropout status clears when condition ends
// [R23] extended enable resets to all zeros
// [R24] one call per instruction boundary only
module iswc_top
  import iswc_pkg::*;
#(
  parameter logic [NUM_SRC-1:0] AUTO_CLEAR = 15'h0005
) (
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_reset,
  // configuration written by the core
  input  wire iswc_pkg::iswc_cfg_type i_cfg,
  input  wire logic                   i_cfg_we,
  // pending flags
  input  wire logic [NUM_SRC-1:0]     i_src_event,
  input  wire logic [NUM_SRC-1:0]     i_sw_set,
  input  wire logic [NUM_SRC-1:0]     i_sw_clear,
  // regulator dropout level, asynchronous
  input  wire logic                   i_dropout_raw,
  // core sequencer handshake
  input  wire logic                   i_insn_boundary,
  input  wire logic                   i_reti_done,
  // power control writes
  input  wire logic                   i_idle_set,
  input  wire logic                   i_stop_set,
  // outputs to the core
  output iswc_pkg::iswc_call_type     o_call,
  output logic [NUM_SRC-1:0]          o_pending,
  output logic                        o_idle,
  output logic                        o_stop,
  output logic                        o_dropout_status,
  output logic [1:0]                  o_active_level
);
  import iswc_pkg::*;

  typedef struct packed {
    iswc_cfg_type       cfg;
    logic [NUM_SRC-1:0] pend;
    logic               act_low;
    logic               act_high;
    logic               hold;
    logic               idle;
    logic               stop;
    logic               dropout;
    iswc_call_type      call;
  } iswc_state_type;

  iswc_state_type state_ff;
  iswc_state_type nxt_state;
  logic           drop_sync;

  if (NUM_SRC != 15 || AUTO_CLEAR[DROPOUT_SRC]) begin : g_bad_cfg
    $error("iswc_top: 15 sources, dropout has no flag to clear");
  end

  iswc_sync #(
    .WIDTH (1)
  ) u_drop_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async (i_dropout_raw),
    .o_sync  (drop_sync)
  );

  // vector address of a source: base plus fixed stride
  function automatic logic [15:0] vec_of(input logic [3:0] s);
    vec_of = VECTOR_BASE + 16'(16'(s) * 16'(VECTOR_STEP));
  endfunction : vec_of

  // lowest index wins among the set bits
  function automatic logic [3:0] pick(input logic [NUM_SRC-1:0] m);
    pick = 4'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (m[i]) pick = 4'(i);
    end
  endfunction : pick

  logic [NUM_SRC-1:0] en_vec;
  logic [NUM_SRC-1:0] pr_vec;
  logic [NUM_SRC-1:0] req;
  logic [NUM_SRC-1:0] req_hi;
  logic [NUM_SRC-1:0] req_lo;
  logic               can_hi;
  logic               can_lo;

  // [R11] requests decoded every clock
  always_comb begin
    // [R7] fifteen enables and priorities
    en_vec = {state_ff.cfg.ext_irq_enable_reg,
              state_ff.cfg.irq_enable_reg[6:0]};
    pr_vec = {state_ff.cfg.ext_irq_priority_reg,
              state_ff.cfg.irq_priority_reg[6:0]};
    // [R3] global enable gate
    // [R21] dropout level stands in for a flag
    req = (state_ff.pend | (NUM_SRC'(state_ff.dropout) << DROPOUT_SRC))
          & en_vec
          & {NUM_SRC{state_ff.cfg.irq_enable_reg[GLOBAL_EN_BIT]}};
    req_hi = req & pr_vec;
    req_lo = req & ~pr_vec;
    // [R8] preemption by level
    // [R14] equal level waits for return
    can_hi = !state_ff.act_high;
    can_lo = !state_ff.act_high && !state_ff.act_low;
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_state.call = '0;
    if (i_cfg_we) begin
      // [R9] priority changes only by its bit
      nxt_state.cfg = i_cfg;
    end
    // [R22] status follows the dropout condition
    nxt_state.dropout = drop_sync;
    // [R12] one instruction after return
    if (i_reti_done) begin
      nxt_state.hold = 1'b1;
      if (state_ff.act_high) nxt_state.act_high = 1'b0;
      else nxt_state.act_low = 1'b0;
    end else if (i_insn_boundary) begin
      nxt_state.hold = 1'b0;
    end
    // [R15] idle entry
    if (i_idle_set) nxt_state.idle = 1'b1;
    // [R19] stop entry, left only by reset
    if (i_stop_set) nxt_state.stop = 1'b1;
    // [R16] enabled request ends idle
    if (state_ff.idle && |req) nxt_state.idle = 1'b0;
    // [R24] one call per boundary
    // [R13] decided in the detect cycle
    // [R10] high level first, then fixed order
    if (i_insn_boundary && !state_ff.hold && !state_ff.stop
        && !i_reti_done) begin
      if (|req_hi && can_hi) begin
        nxt_state.call.valid = 1'b1;
        nxt_state.call.src   = pick(req_hi);
        nxt_state.call.high  = 1'b1;
        nxt_state.act_high   = 1'b1;
      end else if (|req_lo && can_lo) begin
        nxt_state.call.valid = 1'b1;
        nxt_state.call.src   = pick(req_lo);
        nxt_state.call.high  = 1'b0;
        nxt_state.act_low    = 1'b1;
      end
      // [R2] fixed vector per source
      nxt_state.call.vector = vec_of(nxt_state.call.src);
    end
    // [R4] selected flags clear on vectoring
    // [R5] others stay set and re-request
    if (nxt_state.call.valid && AUTO_CLEAR[nxt_state.call.src]) begin
      nxt_state.pend[nxt_state.call.src] = 1'b0;
    end
    nxt_state.pend = nxt_state.pend & ~i_sw_clear;
    // [R1] event sets, winning over a clear
    // [R6] software set acts the same
    nxt_state.pend = nxt_state.pend | i_src_event | i_sw_set;
    nxt_state.pend[DROPOUT_SRC] = 1'b0;
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    // [R17] reset restarts; [R18] watchdog reset lands here
    // [R23] enables reset to zero
    if (i_reset) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_call           = state_ff.call;
  assign o_pending        = state_ff.pend;
  assign o_idle           = state_ff.idle;
  assign o_stop           = state_ff.stop;
  assign o_dropout_status = state_ff.dropout;
  assign o_active_level   = {state_ff.act_high, state_ff.act_low};

  // pending set on event
  pend_set_a: assert property ( // [R1]
    @(posedge i_clk) disable iff (i_reset)
    (i_src_event[0]) |=> o_pending[0])
    else $error("event did not set pending flag");

  call_gated_a: assert property ( // [R3]
    @(posedge i_clk) disable iff (i_reset)
    o_call.valid |-> $past(state_ff.cfg.irq_enable_reg[GLOBAL_EN_BIT]))
    else $error("call while globally disabled");

  high_nopre_a: assert property ( // [R8]
    @(posedge i_clk) disable iff (i_reset)
    ($past(state_ff.act_high) && !$past(i_reti_done)) |-> !o_call.valid)
    else $error("high routine preempted");

  call_vector_a: assert property ( // [R2]
    @(posedge i_clk) disable iff (i_reset)
    o_call.valid |-> o_call.vector == vec_of(o_call.src))
    else $error("wrong vector");

  reti_hold_a: assert property ( // [R12]
    @(posedge i_clk) disable iff (i_reset)
    i_reti_done |=> !o_call.valid)
    else $error("call right after return");

  stop_sticky_a: assert property ( // [R19]
    @(posedge i_clk) disable iff (i_reset)
    o_stop |=> o_stop)
    else $error("stop left without reset");

  drop_flagless_a: assert property ( // [R21]
    @(posedge i_clk) disable iff (i_reset)
    !o_pending[DROPOUT_SRC])
    else $error("dropout has a pending flag");

  boundary_only_a: assert property ( // [R24]
    @(posedge i_clk) disable iff (i_reset)
    o_call.valid |-> $past(i_insn_boundary))
    else $error("call off boundary");

  idle_wake_a: assert property ( // [R16]
    @(posedge i_clk) disable iff (i_reset)
    (o_idle && |req && !i_idle_set) |=> !o_idle)
    else $error("idle not ended by request");

  pend_keep_a: assert property ( // [R4]
    @(posedge i_clk) disable iff (i_reset)
    (o_pending[1] && !i_sw_clear[1] && !AUTO_CLEAR[1]) |=> o_pending[1])
    else $error("flag dropped without a clear");

  auto_clear_a: assert property ( // [R4]
    @(posedge i_clk) disable iff (i_reset)
    (o_call.valid && o_call.src == 4'h2 && AUTO_CLEAR[2]
     && !$past(i_src_event[2]) && !$past(i_sw_set[2])) |-> !o_pending[2])
    else $error("flag not cleared on vectoring");

  sw_set_a: assert property ( // [R6]
    @(posedge i_clk) disable iff (i_reset)
    i_sw_set[0] |=> o_pending[0])
    else $error("software set did not raise flag");

  cfg_stable_a: assert property ( // [R9]
    @(posedge i_clk) disable iff (i_reset)
    !i_cfg_we |=> $stable(state_ff.cfg))
    else $error("configuration changed without a write");

  high_first_a: assert property ( // [R10]
    @(posedge i_clk) disable iff (i_reset)
    (o_call.valid && !o_call.high) |-> $past(req_hi == '0 || !can_hi))
    else $error("low call taken over a high request");

  stop_nocall_a: assert property ( // [R19]
    @(posedge i_clk) disable iff (i_reset)
    $past(o_stop) |-> !o_call.valid)
    else $error("call while stopped");

  idle_entry_a: assert property ( // [R15]
    @(posedge i_clk) disable iff (i_reset)
    (i_idle_set && !o_idle) |=> o_idle)
    else $error("idle not entered");

  drop_status_a: assert property ( // [R22]
    @(posedge i_clk) disable iff (i_reset)
    !drop_sync |=> !o_dropout_status)
    else $error("dropout status stuck after condition ended");

  ext_en_rst_a: assert property ( // [R23]
    @(posedge i_clk)
    i_reset |=> state_ff.cfg.ext_irq_enable_reg == 8'h00)
    else $error("extended enables not cleared by reset");

  reti_release_a: assert property ( // [R14]
    @(posedge i_clk) disable iff (i_reset)
    (i_reti_done && o_active_level[1]) |=> !o_active_level[1])
    else $error("return did not release high level");

  src_range_a: assert property ( // [R7]
    @(posedge i_clk) disable iff (i_reset)
    o_call.valid |-> o_call.src < 4'(NUM_SRC))
    else $error("call to a source out of range");

  hold_block_a: assert property ( // [R12]
    @(posedge i_clk) disable iff (i_reset)
    (state_ff.hold && i_insn_boundary) |=> !o_call.valid)
    else $error("call on the boundary right after return");
endmodule : iswc_top

//--- testbench/iswc_core.sv
// iswc_core: processor sequencer model giving boundaries and returns.
// assumes the call output of iswc_top and halt/return requests.
`timescale 1ns/1ps
module iswc_core
  import iswc_pkg::*;
(
  // clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_reset,
  // controller call and bench requests
  input  wire iswc_pkg::iswc_call_type i_call,
  input  wire logic                    i_halt,
  input  wire logic                    i_reti_req,
  // sequencer strobes
  output logic                         o_insn_boundary,
  output logic                         o_reti_done
);
  logic [2:0] busy_ff;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset)
      busy_ff <= 3'h0;
    else
      busy_ff <= i_call.valid ? 3'h4 : busy_ff - {2'h0, |busy_ff};
  end
  // a return step is no boundary
  assign o_reti_done = i_reti_req && busy_ff == 3'h0 && !i_halt;
  assign o_insn_boundary = busy_ff == 3'h0 && !i_halt && !i_reti_req
    && !i_call.valid;
endmodule : iswc_core

//--- testbench/iswc_top_test.sv
// iswc_top_test: random and directed checks of the interrupt controller.
// assumes iswc_core stands in for the processor sequencer.
`timescale 1ns/1ps
module iswc_top_test;
  import iswc_pkg::*;
  logic          i_clk = 0, i_reset = 1, i_cfg_we = 0;
  logic          i_idle_set = 0, i_stop_set = 0, i_dropout_raw = 0;
  logic          reti_req = 0, boundary, reti_done;
  logic          o_idle, o_stop, o_dropout_status;
  logic [14:0]   i_src_event = 0, i_sw_set = 0, i_sw_clear = 0, o_pending;
  logic [1:0]    o_active_level;
  logic [31:0]   rng = 32'h3052;
  iswc_cfg_type  i_cfg = 0, cfgv = 0;
  iswc_call_type o_call;
  int            errors = 0, compares = 0;
  iswc_top uut (.i_clk, .i_reset, .i_cfg, .i_cfg_we, .i_src_event,
    .i_sw_set, .i_sw_clear, .i_dropout_raw, .i_insn_boundary(boundary),
    .i_reti_done(reti_done), .i_idle_set, .i_stop_set, .o_call,
    .o_pending, .o_idle, .o_stop, .o_dropout_status, .o_active_level);
  iswc_core core (.i_clk, .i_reset, .i_call(o_call),
    .i_halt(o_idle | o_stop), .i_reti_req(reti_req),
    .o_insn_boundary(boundary), .o_reti_done(reti_done));
  initial forever #12.5 i_clk = ~i_clk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xs
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic rst;
    @(posedge i_clk);
    i_reset <= 1;
    repeat (6) @(posedge i_clk);
    i_reset <= 0;
  endtask : rst
  // p is {cfg write, return, stop, idle}; gap lets the call sequence end
  task automatic drive(input logic [14:0] e, s, c, input logic [3:0] p);
    repeat (6) @(posedge i_clk);
    i_cfg <= cfgv;
    {i_src_event, i_sw_set, i_sw_clear} <= {e, s, c};
    {i_cfg_we, reti_req, i_stop_set, i_idle_set} <= p;
    @(posedge i_clk);
    {i_src_event, i_sw_set, i_sw_clear} <= '0;
    {i_cfg_we, reti_req, i_stop_set, i_idle_set} <= 4'h0;
  endtask : drive
  // lat: 0 means no call, -1 any within the bound, else exact cycles
  task automatic call_chk(input int s, input logic h, input int lat);
    int n;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_call.valid !== 1'b1 && n < 20);
    check(o_call.valid, lat != 0);
    if (lat != 0) begin
      if (n == 20)
        complete_run();
      check(lat > 0 ? n : n <= MAX_RESPONSE, lat > 0 ? lat : 1);
      check({o_call.high, o_call.src}, {h, s[3:0]});
      check(o_call.vector, VECTOR_BASE + 16'(VECTOR_STEP * s));
    end
  endtask : call_chk
  initial begin
    logic [14:0] exp;
    exp = '0;
    rst();
    check({o_pending, o_stop, o_idle, o_active_level}, 0);
    for (int i = 0; i < 30; i++) begin
      rng = xs(rng);
      drive(rng[14:0], 0, rng[30:16] & ~rng[14:0], 0);
      exp = (exp & ~rng[30:16]) | rng[14:0];
      @(negedge i_clk);
      check(o_pending, exp & 15'h5fff);
    end
    drive(0, 15'h7fff, 0, 0);
    call_chk(0, 0, 0);
    check(o_pending, 15'h5fff);
    rst();
    cfgv = {8'h0e, 8'h00, 8'h08, 8'h00};
    drive(15'h0002, 0, 0, 4'h8);
    call_chk(0, 0, 0);
    cfgv.irq_enable_reg[GLOBAL_EN_BIT] = 1'b1;
    drive(0, 0, 0, 4'h8);
    call_chk(1, 0, -1);
    drive(15'h0004, 0, 0, 0);
    call_chk(0, 0, 0);
    drive(15'h0008, 0, 0, 0);
    call_chk(3, 1, 2);
    check(o_active_level, 2'h3);
    drive(15'h0008, 0, 0, 0);
    call_chk(0, 0, 0);
    drive(0, 0, 0, 4'h4);
    call_chk(3, 1, 3);
    drive(0, 0, 15'h000a, 4'h4);
    call_chk(0, 0, 0);
    drive(0, 0, 0, 4'h4);
    call_chk(2, 0, 3);
    @(negedge i_clk);
    check(o_pending, 0);
    rst();
    cfgv = {8'h82, 8'h00, 8'h00, 8'h00};
    drive(0, 0, 0, 4'h9);
    repeat (6) @(negedge i_clk);
    check(o_idle, 1);
    drive(15'h0002, 0, 0, 0);
    call_chk(1, 0, -1);
    check(o_idle, 0);
    drive(0, 0, 15'h0002, 4'h1);
    repeat (2) @(negedge i_clk);
    check(o_idle, 1);
    rst();
    check(o_idle, 0);
    // request while stopped draws no call, only rst ends stop
    drive(0, 0, 0, 4'ha);
    drive(15'h0002, 0, 0, 0);
    call_chk(0, 0, 0);
    check(o_stop, 1);
    rst();
    check(o_stop, 0);
    cfgv = {8'h80, 8'h41, 8'h00, 8'h01};
    drive(0, 15'h0080, 0, 4'h8);
    call_chk(7, 1, 2);
    drive(0, 0, 15'h0080, 4'h4);
    @(negedge i_clk);
    check(o_active_level, 0);
    cfgv = {8'h80, 8'h40, 8'h00, 8'h00};
    drive(0, 0, 0, 4'h8);
    i_dropout_raw <= 1;
    call_chk(13, 0, -1);
    check({o_pending[13], o_dropout_status}, 1);
    @(posedge i_clk);
    i_dropout_raw <= 0;
    repeat (5) @(negedge i_clk);
    check(o_dropout_status, 0);
    complete_run();
  end
endmodule : iswc_top_test
